// *** rcg_pkg.sv ***
// Package of the remote command gate: command codes, register map, timing.
// Assumes a single 25 MHz system clock and a classic Wishbone register slave.
package rcg_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int PULSE_MIN_MS = 25;
    // Least time, so round up to whole cycles
    localparam int FILTER_CYC = (PULSE_MIN_MS * CLK_HZ + 999) / 1000;

    // ==========================================================
    // Sizes
    localparam int N_CMD = 14;
    localparam int SEL_W = 4;
    localparam int N_ARM = 16;

    // ==========================================================
    // Command codes, also the bit index on the remote command pins
    typedef enum logic [3:0] {
        CMD_DRIVE_ENERGIZE = 4'h0,
        CMD_DRIVE_DEENERGIZE = 4'h1,
        CMD_FULL_POWER_REQUEST = 4'h2,
        CMD_REDUCED_POWER_REQUEST = 4'h3,
        CMD_CALIBRATE = 4'h4,
        CMD_RETURN_ORIGIN = 4'h5,
        CMD_START = 4'h6,
        CMD_PAUSE = 4'h7,
        CMD_RESUME = 4'h8,
        CMD_KILL_ALL_TASKS = 4'h9,
        CMD_RESET = 4'hA,
        CMD_RECOVER = 4'hB,
        CMD_HALT = 4'hC,
        CMD_RESTART = 4'hD
    } rcg_cmd_t;

    // Dispatcher states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } rcg_state_t;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DRIVE = 8'h08;
    localparam logic [7:0] REG_CAL = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_ERR_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int ST_PAUSED_BIT = 3;
    localparam int ST_MULTI_BIT = 4;
    localparam int ST_ARM_LSB = 8;
    localparam int ST_GRP_LSB = 12;
    localparam int HI_HALF_LSB = 16;
endpackage

// *** rcg_cmd_if.sv ***
// Interface carrying the qualified remote command lines and select codes.
// Assumes rcg_pkg is compiled first; one source and one sink on one clock.
interface rcg_cmd_if;
    logic [rcg_pkg::N_CMD-1:0] cmd;
    logic [rcg_pkg::SEL_W-1:0] arm;
    logic [rcg_pkg::SEL_W-1:0] grp;
    modport src (output cmd, output arm, output grp);
    modport dst (input cmd, input arm, input grp);
endinterface

// *** rcg_sync3.sv ***
// Three-stage synchroniser for pin inputs, one chain per bit.
// Assumes asynchronous pins; output changes only once stages two and three agree.
module rcg_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // ==========================================================
    // Chain; the first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Take the value where two and three agree, hold otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= '0;
        end else begin
            q_o <= (s2 & s3) | (q_o & (s2 | s3));
        end
    end
endmodule

// *** rcg_pulse_qual.sv ***
// Pulse width qualifier: passes the command and select vector on only once
// it has stood unchanged for FILT cycles. Assumes synchronised inputs.
module rcg_pulse_qual #(
    parameter int W = rcg_pkg::N_CMD + 2 * rcg_pkg::SEL_W,
    parameter int FILT = rcg_pkg::FILTER_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Synchronised {group, arm, commands}
    input wire logic [W-1:0] d_i,
    // Qualified lines
    rcg_cmd_if.src q
);
    import rcg_pkg::*;
    localparam int CW = $clog2(FILT + 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(FILT - 1);

    logic [W-1:0] last;
    logic [CW-1:0] cnt;
    logic take;

    assign take = (d_i == last) && (cnt == LAST_CNT);

    // ==========================================================
    // Stability counter; any change restarts it, so short pulses vanish
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last <= '0;
            cnt <= '0;
        end else if (d_i != last) begin
            last <= d_i;
            cnt <= '0;
        end else if (cnt != LAST_CNT) begin
            cnt <= cnt + CW'(1);
        end
    end

    // Qualified vector, selects taken together with the commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.cmd <= '0;
            q.arm <= '0;
            q.grp <= '0;
        end else if (take) begin // RQ20
            {q.grp, q.arm, q.cmd} <= last;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_qual_hold;
        !take |=> $stable(q.cmd) && $stable(q.arm);
    endproperty
    a_qual_hold: assert property (p_qual_hold) else $error("qualified lines moved early"); // RQ20

    property p_qual_take;
        take |=> q.cmd == $past(last[N_CMD-1:0]);
    endproperty
    a_qual_take: assert property (p_qual_take) else $error("stable command not passed on"); // RQ20
endmodule

// *** rcg_gate.sv ***
// Remote command gate: accepts remote discrete commands, checks them
// against task and error state, and dispatches them to the controller core.
// Assumes remote pins are asynchronous and the core signals are on clk_i.
//
// How it works
// RQ1: Energize drives of chosen arm if deenergize line idle; refused while tasks run.
// RQ2: Deenergize turns chosen arm's drives off, blocks energize; refused while tasks run.
// RQ3: Full power needs drives on and reduced line idle; refused while tasks run.
// RQ4: Reduced power leaves full power, blocks full power; refused while tasks run.
// RQ5: Calibrate and return to origin act on chosen arm; refused while tasks run.
// RQ6: Start launches the selected program set; refused while tasks run.
// RQ7: Pause suspends pausable tasks; accepted only while tasks run.
// RQ8: Resume continues paused tasks; accepted only while tasks run.
// RQ9: Kill all tasks is accepted whatever the task state.
// RQ10: While error is on only reset is accepted; reset clears the error.
// RQ11: After an error every other command is refused until reset.
// RQ12: Arm select is a 4-bit binary code; code N picks arm N+1.
// RQ13: Arm select steers arm commands and the per-arm status outputs.
// RQ14: Start uses program set code from four select lines, set = code + 1.
// RQ15: Select lines read OFF as 0, ON as 1, weight 1 is the LSB.
// RQ16: Recover starts position recovery once the safeguard is closed again.
// RQ17: Halt and restart stop or reboot the controller; refused while tasks run.
// RQ18: Remote side should watch the error output and use reset.
// RQ19: Remote side drives one command at a time; several raise an error.
// RQ20: Pulses shorter than 25 ms are ignored.
// RQ21: Command in cycle stays on while an accepted command executes.
// RQ22: Inputs are synchronised; each command acts once, on its rising edge.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
module rcg_gate #(
    parameter int FILTER_CYCLES = rcg_pkg::FILTER_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Remote pins
    input wire logic [rcg_pkg::N_CMD-1:0] remote_cmd_i,
    input wire logic [rcg_pkg::SEL_W-1:0] arm_select_i,
    input wire logic [rcg_pkg::SEL_W-1:0] prog_set_select_i,
    // Controller core state
    input wire logic tasks_running_i,
    input wire logic paused_i,
    input wire logic safeguard_closed_i,
    input wire logic op_done_i,
    input wire logic fault_i,
    // Dispatch to the core
    output logic exec_valid_o,
    output rcg_pkg::rcg_cmd_t exec_code_o,
    output logic [rcg_pkg::SEL_W-1:0] exec_arm_o,
    output logic [rcg_pkg::SEL_W-1:0] exec_group_o,
    // Remote status
    output logic command_in_cycle_o,
    output logic error_o,
    output logic remote_ready_o,
    output logic motor_mode_o,
    output logic power_mode_o,
    output logic calibration_done_o,
    output logic at_origin_o,
    output logic [rcg_pkg::SEL_W-1:0] active_arm_code_o
);
    import rcg_pkg::*;

    localparam int SW = N_CMD + 2 * SEL_W;

    logic [SW-1:0] sync_all;
    logic [N_CMD-1:0] prev_cmd;
    logic [N_CMD-1:0] rise;
    logic multi;
    logic ok;
    logic err_set;
    logic multi_err;
    logic ctrl_en;
    logic wb_hit;
    logic [31:0] rd_data;
    logic [N_ARM-1:0] motor_mode;
    logic [N_ARM-1:0] power_mode;
    logic [N_ARM-1:0] cal_done;
    logic [N_ARM-1:0] at_origin;
    rcg_cmd_t code;
    rcg_state_t state;
    rcg_state_t next_state;

    rcg_cmd_if cif();

    // ==========================================================
    // Input conditioning
    // Commands and selects share one chain so the codes line up with the edge
    rcg_sync3 #(.W(SW)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({prog_set_select_i, arm_select_i, remote_cmd_i}), // RQ22
        .q_o(sync_all)
    );

    rcg_pulse_qual #(.W(SW), .FILT(FILTER_CYCLES)) u_qual (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sync_all),
        .q(cif.src)
    );

    // ==========================================================
    // Edge detection; a held line acts only once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_cmd <= '0;
        end else begin
            prev_cmd <= cif.cmd;
        end
    end

    function automatic rcg_cmd_t first_bit(input logic [N_CMD-1:0] v);
        rcg_cmd_t c;
        c = CMD_DRIVE_ENERGIZE;
        for (int i = N_CMD - 1; i >= 0; i--) begin
            if (v[i]) begin
                c = rcg_cmd_t'(4'(i));
            end
        end
        return c;
    endfunction

    assign rise = cif.cmd & ~prev_cmd; // RQ22
    assign multi = (cif.cmd & (cif.cmd - N_CMD'(1))) != '0;
    assign code = first_bit(rise);

    // ==========================================================
    // Acceptance; several lines at once are never executed
    always_comb begin
        ok = 1'b0;
        if (!(|rise) || multi) begin
            ok = 1'b0;
        end else if (error_o) begin
            ok = (code == CMD_RESET); // RQ10 RQ11
        end else if (!ctrl_en) begin
            ok = 1'b0;
        end else if (state == ST_BUSY) begin
            ok = (code == CMD_KILL_ALL_TASKS); // RQ9
        end else begin
            unique case (code)
                CMD_DRIVE_ENERGIZE: begin
                    ok = !tasks_running_i && !cif.cmd[CMD_DRIVE_DEENERGIZE]; // RQ1
                end
                CMD_FULL_POWER_REQUEST: begin
                    ok = !tasks_running_i && motor_mode[cif.arm] && !cif.cmd[CMD_REDUCED_POWER_REQUEST]; // RQ3
                end
                CMD_DRIVE_DEENERGIZE, CMD_REDUCED_POWER_REQUEST: begin
                    ok = !tasks_running_i; // RQ2 RQ4
                end
                CMD_CALIBRATE, CMD_RETURN_ORIGIN, CMD_START: begin
                    ok = !tasks_running_i; // RQ5 RQ6
                end
                CMD_HALT, CMD_RESTART: begin
                    ok = !tasks_running_i; // RQ17
                end
                CMD_PAUSE, CMD_RESUME: begin
                    ok = tasks_running_i; // RQ7 RQ8
                end
                CMD_KILL_ALL_TASKS, CMD_RESET: begin
                    ok = 1'b1; // RQ9
                end
                CMD_RECOVER: begin
                    ok = safeguard_closed_i; // RQ16
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Error flag; a new fault beats a reset in the same cycle
    assign err_set = ((|rise) && multi) || fault_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_o <= 1'b0;
            multi_err <= 1'b0;
        end else if (err_set) begin
            error_o <= 1'b1; // RQ11 RQ19
            multi_err <= multi_err || ((|rise) && multi);
        end else if (ok && code == CMD_RESET) begin
            error_o <= 1'b0; // RQ10
            multi_err <= 1'b0;
        end
    end

    // ==========================================================
    // Dispatcher: busy from acceptance until the core reports completion
    always_comb begin
        unique case (state)
            ST_IDLE: next_state = ok ? ST_BUSY : ST_IDLE;
            ST_BUSY: next_state = (op_done_i && !ok) ? ST_IDLE : ST_BUSY;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            command_in_cycle_o <= 1'b0;
        end else begin
            state <= next_state;
            command_in_cycle_o <= (next_state == ST_BUSY); // RQ21
        end
    end

    // Command strobe with the codes sampled at the edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exec_valid_o <= 1'b0;
            exec_code_o <= CMD_DRIVE_ENERGIZE;
            exec_arm_o <= '0;
            exec_group_o <= '0;
        end else begin
            exec_valid_o <= ok;
            if (ok) begin
                exec_code_o <= code;
                exec_arm_o <= cif.arm; // RQ12 RQ13
                exec_group_o <= cif.grp; // RQ14 RQ15
            end
        end
    end

    // ==========================================================
    // Per-arm user settings; they record the request, not the live drive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_mode <= '0;
            power_mode <= '0;
        end else if (ok) begin
            if (code == CMD_DRIVE_ENERGIZE) begin
                motor_mode[cif.arm] <= 1'b1; // RQ1
            end
            if (code == CMD_DRIVE_DEENERGIZE) begin
                motor_mode[cif.arm] <= 1'b0; // RQ2
            end
            if (code == CMD_FULL_POWER_REQUEST) begin
                power_mode[cif.arm] <= 1'b1; // RQ3
            end
            if (code == CMD_REDUCED_POWER_REQUEST) begin
                power_mode[cif.arm] <= 1'b0; // RQ4
            end
        end
    end

    // Calibration and origin flags are set when the core finishes the move
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_done <= '0;
            at_origin <= '0;
        end else if (state == ST_BUSY && op_done_i && !ok) begin
            if (exec_code_o == CMD_CALIBRATE) begin
                cal_done[exec_arm_o] <= 1'b1; // RQ5
            end
            if (exec_code_o == CMD_RETURN_ORIGIN) begin
                at_origin[exec_arm_o] <= 1'b1; // RQ5
            end
        end
    end

    // Status of the currently selected arm
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_mode_o <= 1'b0;
            power_mode_o <= 1'b0;
            calibration_done_o <= 1'b0;
            at_origin_o <= 1'b0;
            active_arm_code_o <= '0;
            remote_ready_o <= 1'b0;
        end else begin
            motor_mode_o <= motor_mode[cif.arm]; // RQ13
            power_mode_o <= power_mode[cif.arm];
            calibration_done_o <= cal_done[cif.arm];
            at_origin_o <= at_origin[cif.arm];
            active_arm_code_o <= cif.arm; // RQ12
            remote_ready_o <= ctrl_en && !error_o;
        end
    end

    // ==========================================================
    // Wishbone slave: one wait state, unmapped reads return zero
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            REG_CTRL: rd_data[CTRL_EN_BIT] = ctrl_en;
            REG_STATUS: begin
                rd_data[ST_ERR_BIT] = error_o;
                rd_data[ST_BUSY_BIT] = command_in_cycle_o;
                rd_data[ST_RUN_BIT] = tasks_running_i;
                rd_data[ST_PAUSED_BIT] = paused_i;
                rd_data[ST_MULTI_BIT] = multi_err;
                rd_data[ST_ARM_LSB +: SEL_W] = cif.arm;
                rd_data[ST_GRP_LSB +: SEL_W] = cif.grp;
            end
            REG_DRIVE: rd_data = {power_mode, motor_mode};
            REG_CAL: rd_data = {at_origin, cal_done};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Remote enable gates every command except reset during an error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_en <= CTRL_EN_RST;
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            ctrl_en <= wb_dat_i[CTRL_EN_BIT];
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_issue(rcg_cmd_t c);
        exec_valid_o && exec_code_o == c;
    endsequence

    property p_energize;
        s_issue(CMD_DRIVE_ENERGIZE) |-> $past(!tasks_running_i && !cif.cmd[CMD_DRIVE_DEENERGIZE]);
    endproperty
    a_energize: assert property (p_energize) else $error("energize taken while blocked"); // RQ1

    property p_deenergize;
        s_issue(CMD_DRIVE_DEENERGIZE) |-> !motor_mode[exec_arm_o] ##1 !motor_mode_o || $changed(cif.arm);
    endproperty
    a_deenergize: assert property (p_deenergize) else $error("drives still on after deenergize"); // RQ2

    property p_full_power;
        s_issue(CMD_FULL_POWER_REQUEST) |-> $past(motor_mode[cif.arm] && !tasks_running_i);
    endproperty
    a_full_power: assert property (p_full_power) else $error("full power without drives on"); // RQ3

    property p_pause;
        (s_issue(CMD_PAUSE) or s_issue(CMD_RESUME)) |-> $past(tasks_running_i);
    endproperty
    a_pause: assert property (p_pause) else $error("pause or resume with no tasks"); // RQ7

    property p_err_only_reset;
        exec_valid_o && $past(error_o) |-> exec_code_o == CMD_RESET;
    endproperty
    a_err_only_reset: assert property (p_err_only_reset) else $error("command taken during error"); // RQ10

    property p_multi_err;
        (|rise) && multi |=> error_o && !exec_valid_o;
    endproperty
    a_multi_err: assert property (p_multi_err) else $error("several commands not flagged"); // RQ19

    property p_group;
        s_issue(CMD_START) |-> exec_group_o == $past(cif.grp) && $past(!tasks_running_i);
    endproperty
    a_group: assert property (p_group) else $error("start group or task check wrong"); // RQ6

    property p_in_cycle;
        exec_valid_o |-> command_in_cycle_o ##1 (command_in_cycle_o || $past(op_done_i));
    endproperty
    a_in_cycle: assert property (p_in_cycle) else $error("command in cycle dropped early"); // RQ21

    property p_once;
        exec_valid_o |=> !exec_valid_o;
    endproperty
    a_once: assert property (p_once) else $error("command acted twice"); // RQ22

    property p_arm_code;
        ##1 active_arm_code_o == $past(cif.arm);
    endproperty
    a_arm_code: assert property (p_arm_code) else $error("arm code not reported"); // RQ12
endmodule

// *** rcg_core_model.sv ***
// Controller core model: answers each dispatched command, keeps task state.
// Assumes rcg_pkg is compiled first; one clock, synchronous active-high reset.
module rcg_core_model
    import rcg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Dispatch from the gate
    input wire logic exec_valid_i,
    input wire rcg_pkg::rcg_cmd_t exec_code_i,
    // State back to the gate
    output logic op_done_o,
    output logic running_o,
    output logic paused_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt;

    // ==========================================
    // Completion
    // A late answer, so that the busy window is really seen
    always_ff @(posedge clk_i) begin
        if (rst_i || exec_valid_i) begin
            wait_cnt <= rst_i ? 2'h0 : 2'h3;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
        op_done_o <= !rst_i && (wait_cnt == 2'h1);
    end

    // Task state follows start, pause, resume and kill
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            running_o <= 1'b0;
            paused_o <= 1'b0;
        end else if (exec_valid_i) begin
            case (exec_code_i)
                CMD_START: running_o <= 1'b1;
                CMD_PAUSE: paused_o <= 1'b1;
                CMD_RESUME: paused_o <= 1'b0;
                CMD_KILL_ALL_TASKS: running_o <= 1'b0;
                default: ;
            endcase
        end
    end
endmodule

// *** testbench.sv ***
// Self-checking bench of the remote command gate.
// Assumes rcg_pkg, rcg_cmd_if and the gate modules are compiled first.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import rcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, exec_valid_o, op_done_i;
    logic tasks_running_i, paused_i, command_in_cycle_o, error_o, remote_ready_o, motor_mode_o;
    logic power_mode_o, calibration_done_o, at_origin_o, seen_busy, safeguard_closed_i;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [13:0] remote_cmd_i;
    logic [3:0] arm_select_i, prog_set_select_i, exec_arm_o, exec_group_o, active_arm_code_o, got_arm, got_grp;
    rcg_cmd_t exec_code_o, got_code;
    int bad_count, samples_checked, n_disp, cycles;

    // Short filter keeps each command to a few cycles
    rcg_gate #(.FILTER_CYCLES(4)) uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .remote_cmd_i, .arm_select_i,
        .prog_set_select_i, .tasks_running_i, .paused_i, .safeguard_closed_i, .op_done_i,
        .fault_i(1'b0), .exec_valid_o, .exec_code_o, .exec_arm_o, .exec_group_o, .command_in_cycle_o,
        .error_o, .remote_ready_o, .motor_mode_o, .power_mode_o, .calibration_done_o, .at_origin_o,
        .active_arm_code_o);
    rcg_core_model core (.clk_i, .rst_i, .exec_valid_i(exec_valid_o), .exec_code_i(exec_code_o),
        .op_done_o(op_done_i), .running_o(tasks_running_i), .paused_o(paused_i));

    // ==========================================
    // Clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Ceiling well above the roughly 1300 cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic end_of_test();
        $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Classic single read or write, waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Panel holds one vector well past the filter, then releases it
    task automatic send(input logic [13:0] v, input logic [3:0] a, input logic [3:0] g);
        n_disp = 0;
        seen_busy = 1'b0;
        @(posedge clk_i);
        remote_cmd_i <= v;
        arm_select_i <= a;
        prog_set_select_i <= g;
        repeat (24) begin
            @(posedge clk_i);
            if (exec_valid_o === 1'b1) begin
                n_disp++;
                got_code = exec_code_o;
                got_arm = exec_arm_o;
                got_grp = exec_group_o;
            end
            if (command_in_cycle_o === 1'b1) seen_busy = 1'b1;
        end
        remote_cmd_i <= '0;
        repeat (24) @(posedge clk_i);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs();
        wb(1'b0, REG_CTRL, 32'h0, rd);
        `CHK(rd[CTRL_EN_BIT], CTRL_EN_RST)
        // Remote disabled: a clean energize must not be dispatched
        wb(1'b1, REG_CTRL, 32'h0, rd);
        send(14'h0001, 4'h1, 4'h0);
        `CHK(n_disp, 0)
        `CHK(remote_ready_o, 1'b0)
        wb(1'b0, REG_CTRL, 32'h0, rd);
        `CHK(rd[CTRL_EN_BIT], 1'b0)
        wb(1'b1, REG_CTRL, 32'h1, rd);
        wb(1'b0, 8'h10, 32'h0, rd);
        `CHK(rd, 32'h0)
        $display("t_regs done");
    endtask
    task automatic t_drive();
        send(14'h0001, 4'h5, 4'h0);
        `CHK(n_disp, 1)
        `CHK(got_code, CMD_DRIVE_ENERGIZE)
        `CHK(got_arm, 4'h5)
        `CHK(active_arm_code_o, 4'h5)
        `CHK(motor_mode_o, 1'b1)
        `CHK(seen_busy, 1'b1)
        `CHK(command_in_cycle_o, 1'b0)
        send(14'h0004, 4'h5, 4'h0);
        `CHK(power_mode_o, 1'b1)
        send(14'h0004, 4'h6, 4'h0);
        `CHK(n_disp, 0)
        send(14'h0010, 4'h5, 4'h0);
        `CHK(calibration_done_o, 1'b1)
        send(14'h0020, 4'h5, 4'h0);
        `CHK(at_origin_o, 1'b1)
        send(14'h0002, 4'h5, 4'h0);
        `CHK(motor_mode_o, 1'b0)
        $display("t_drive done");
    endtask
    task automatic t_tasks();
        int refused[9] = '{0, 1, 2, 3, 4, 5, 6, 12, 13};
        send(14'h0080, 4'h0, 4'h0);
        `CHK(n_disp, 0)
        send(14'h0040, 4'h0, 4'h9);
        `CHK(got_grp, 4'h9)
        `CHK(n_disp, 1)
        foreach (refused[i]) begin
            send(14'h0001 << refused[i], 4'h0, 4'h0);
            `CHK(n_disp, 0)
        end
        send(14'h0080, 4'h0, 4'h0);
        `CHK(got_code, CMD_PAUSE)
        send(14'h0100, 4'h0, 4'h0);
        `CHK(got_code, CMD_RESUME)
        send(14'h0200, 4'h0, 4'h0);
        `CHK(n_disp, 1)
        safeguard_closed_i <= 1'b0;
        send(14'h0800, 4'h0, 4'h0);
        `CHK(n_disp, 0)
        safeguard_closed_i <= 1'b1;
        send(14'h0800, 4'h0, 4'h0);
        `CHK(got_code, CMD_RECOVER)
        $display("t_tasks done");
    endtask
    task automatic t_error();
        send(14'h0003, 4'h0, 4'h0);
        `CHK(error_o, 1'b1)
        wb(1'b0, REG_STATUS, 32'h0, rd);
        `CHK(rd[ST_MULTI_BIT], 1'b1)
        send(14'h0200, 4'h0, 4'h0);
        `CHK(n_disp, 0)
        send(14'h0400, 4'h0, 4'h0);
        `CHK(n_disp, 1)
        `CHK(error_o, 1'b0)
        $display("t_error done");
    endtask

    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {remote_cmd_i, arm_select_i, prog_set_select_i} = '0;
        safeguard_closed_i = 1'b1;
        {bad_count, samples_checked, cycles} = '0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_drive();
        t_tasks();
        t_error();
        end_of_test();
    end
endmodule
